// ### shared/ucr_pkg.sv
// ==========================================================
// channel register map constants
package ucr_pkg;

   // ==========================================================
   // location offsets on the four address lines
   localparam logic [3:0] OFS_HOLD      = 4'h0; // rx/tx holding, divisor low
   localparam logic [3:0] OFS_IER       = 4'h1; // interrupt enable, divisor high
   localparam logic [3:0] OFS_ISR_FCR   = 4'h2;
   localparam logic [3:0] OFS_LCR       = 4'h3;
   localparam logic [3:0] OFS_MCR       = 4'h4;
   localparam logic [3:0] OFS_LSR       = 4'h5;
   localparam logic [3:0] OFS_MSR       = 4'h6; // write side is turnaround delay
   localparam logic [3:0] OFS_SPR       = 4'h7;
   localparam logic [3:0] OFS_FEATURE_CONTROL      = 4'h8;
   localparam logic [3:0] OFS_EFR       = 4'h9;
   localparam logic [3:0] OFS_TXLVL     = 4'ha;
   localparam logic [3:0] OFS_RXLVL     = 4'hb;
   localparam logic [3:0] OFS_XFLAG     = 4'hc; // write side is stop char 1
   localparam logic [3:0] OFS_STOP_CHAR_2     = 4'hd;
   localparam logic [3:0] OFS_RESUME_CHAR_1      = 4'he;
   localparam logic [3:0] OFS_RESUME_CHAR_2      = 4'hf;

   // ==========================================================
   // field positions
   localparam int LCR_DIV_BIT           = 7;  // divisor latch select
   localparam int EFR_ENH_BIT           = 4;  // enhanced-function enable
   localparam int MCR_OUT1_BIT          = 2;  // general output one
   localparam int MCR_OUT2_BIT          = 3;  // general output two
   localparam int MCR_LOOP_BIT          = 4;  // internal loopback
   localparam int FCR_EN_BIT            = 0;
   localparam int FCR_RXRST_BIT         = 1;
   localparam int FCR_TXRST_BIT         = 2;
   localparam int XF_XOFF_BIT           = 0;
   localparam int XF_XON_BIT            = 1;
   localparam int MSR_RI_BIT            = 6;
   localparam int MSR_CD_BIT            = 7;

   // ==========================================================
   // masks of the enhanced fields, per register
   localparam logic [7:0] ENH_IER_MASK  = 8'hf0; // bits 7:4
   localparam logic [7:0] ENH_ISR_MASK  = 8'h30; // bits 5:4
   localparam logic [7:0] ENH_FCR_MASK  = 8'h30; // bits 5:4
   localparam logic [7:0] ENH_MCR_MASK  = 8'he0; // bits 7:5
   localparam logic [7:0] ENH_MSR_MASK  = 8'hf0; // bits 7:4

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_DIV_LOW   = 8'h01;
   localparam logic [3:0] RST_DLY       = 4'h0;

endpackage : ucr_pkg

// ### logic/ucr_channel_regs.sv
// What this block does
// - extended fields act only while enhanced function bit 4 is one.
// - that bit gates ier 7:4, isr 5:4, fcr 5:4, mcr 7:5, msr 7:4.
// - general output bits two and three drive no pins.
// - general outputs stay register state, looped internally in loopback mode.
// - rx holding is read only; writes never alter received data.
// - tx holding is write only; reading that address returns receive data.
// - four address lines plus read/write direction select the location; divisor latch bit 7 also selects it at offsets 0 and 1.
`timescale 1ns/10ps

module ucr_channel_regs
   import ucr_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // host parallel bus
   input  wire logic [3:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic      [7:0] bus_rdata_q,
   // channel status from the serial side
   input  wire logic [7:0] rx_data,
   input  wire logic [5:0] int_code,
   input  wire logic [7:0] line_stat,
   input  wire logic [7:0] modem_stat,
   input  wire logic [7:0] tx_level,
   input  wire logic [7:0] rx_level,
   input  wire logic       xon_seen,
   input  wire logic       xoff_seen,
   // strobes toward the serial side
   output logic      [7:0] tx_data_q,
   output logic            tx_load_q,
   output logic            rx_pop_q,
   output logic            rx_fifo_rst_q,
   output logic            tx_fifo_rst_q,
   output logic            lsr_read_q,
   output logic            msr_read_q,
   output logic            isr_read_q,
   // configuration toward the serial side
   output logic      [7:0] divisor_low_q,
   output logic      [7:0] divisor_high_byte_q,
   output logic      [7:0] interrupt_enable_reg_q,
   output logic      [7:0] fifo_control_reg_q,
   output logic      [7:0] line_control_reg_q,
   output logic      [7:0] modem_control_reg_q,
   output logic      [7:0] feature_control_q,
   output logic      [7:0] enhanced_function_reg_q,
   output logic      [7:0] tx_thresh_q,
   output logic      [7:0] rx_thresh_q,
   output logic      [7:0] stop_char_1_q,
   output logic      [7:0] stop_char_2_q,
   output logic      [7:0] resume_char_1_q,
   output logic      [7:0] resume_char_2_q,
   output logic      [3:0] turn_delay_q,
   output logic      [1:0] xflag_q
);

   // ==========================================================
   // helpers

   // keep old value in masked bits unless the enhanced bit is set
   function automatic logic [7:0] enh_merge(input logic       enh,
                                            input logic [7:0] mask,
                                            input logic [7:0] newv,
                                            input logic [7:0] oldv);
      enh_merge = enh ? newv : ((newv & ~mask) | (oldv & mask));
   endfunction

   // force masked bits to zero unless the enhanced bit is set
   function automatic logic [7:0] enh_hide(input logic       enh,
                                           input logic [7:0] mask,
                                           input logic [7:0] v);
      enh_hide = enh ? v : (v & ~mask);
   endfunction

   // ==========================================================
   // next-state signals
   logic [7:0] spr_q;
   logic [7:0] spr_d;
   logic [7:0] rdata_d;
   logic [7:0] tx_data_d;
   logic       tx_load_d;
   logic       rx_pop_d;
   logic       rx_fifo_rst_d;
   logic       tx_fifo_rst_d;
   logic       lsr_read_d;
   logic       msr_read_d;
   logic       isr_read_d;
   logic [7:0] dll_d;
   logic [7:0] dlm_d;
   logic [7:0] ier_d;
   logic [7:0] fcr_d;
   logic [7:0] lcr_d;
   logic [7:0] mcr_d;
   logic [7:0] feature_control_d;
   logic [7:0] efr_d;
   logic [7:0] tx_fifo_threshold_d;
   logic [7:0] rx_fifo_threshold_d;
   logic [7:0] stop_char_1_d;
   logic [7:0] stop_char_2_d;
   logic [7:0] resume_char_1_d;
   logic [7:0] resume_char_2_d;
   logic [3:0] dly_d;
   logic [1:0] xflag_d;
   logic       enh;
   logic       dlab;
   logic [7:0] msr_view;

   assign enh  = enhanced_function_reg_q[EFR_ENH_BIT];
   assign dlab = line_control_reg_q[LCR_DIV_BIT];

   // ==========================================================
   // modem status as the host sees it
   always_comb begin
      msr_view = modem_stat;
      if (modem_control_reg_q[MCR_LOOP_BIT]) begin
         // general outputs feed ring and carrier bits internally
         msr_view[MSR_RI_BIT] = modem_control_reg_q[MCR_OUT1_BIT];
         msr_view[MSR_CD_BIT] = modem_control_reg_q[MCR_OUT2_BIT];
      end
      msr_view = enh_hide(enh, ENH_MSR_MASK, msr_view);
   end

   // ==========================================================
   // next values of the register file
   always_comb begin
      spr_d         = spr_q;
      rdata_d       = bus_rdata_q;
      tx_data_d     = tx_data_q;
      tx_load_d     = 1'b0;
      rx_pop_d      = 1'b0;
      rx_fifo_rst_d = 1'b0;
      tx_fifo_rst_d = 1'b0;
      lsr_read_d    = 1'b0;
      msr_read_d    = 1'b0;
      isr_read_d    = 1'b0;
      dll_d         = divisor_low_q;
      dlm_d         = divisor_high_byte_q;
      ier_d         = interrupt_enable_reg_q;
      fcr_d         = fifo_control_reg_q;
      lcr_d         = line_control_reg_q;
      mcr_d         = modem_control_reg_q;
      feature_control_d        = feature_control_q;
      efr_d         = enhanced_function_reg_q;
      tx_fifo_threshold_d       = tx_thresh_q;
      rx_fifo_threshold_d       = rx_thresh_q;
      stop_char_1_d       = stop_char_1_q;
      stop_char_2_d       = stop_char_2_q;
      resume_char_1_d        = resume_char_1_q;
      resume_char_2_d        = resume_char_2_q;
      dly_d         = turn_delay_q;
      xflag_d       = xflag_q;

      // write decode; a write takes priority over a read in the same cycle
      if (bus_wr) begin
         if (bus_addr == OFS_HOLD && dlab) begin
            dll_d = bus_wdata;
         end else if (bus_addr == OFS_HOLD) begin
            tx_data_d = bus_wdata;
            tx_load_d = 1'b1;
         end else if (bus_addr == OFS_IER && dlab) begin
            dlm_d = bus_wdata;
         end else if (bus_addr == OFS_IER) begin
            ier_d = enh_merge(enh, ENH_IER_MASK, bus_wdata, interrupt_enable_reg_q);
         end else if (bus_addr == OFS_ISR_FCR) begin
            fcr_d = enh_merge(enh, ENH_FCR_MASK, bus_wdata, fifo_control_reg_q);
            fcr_d[FCR_RXRST_BIT] = 1'b0;                         // reset bits self-clear
            fcr_d[FCR_TXRST_BIT] = 1'b0;
            rx_fifo_rst_d = bus_wdata[FCR_RXRST_BIT];
            tx_fifo_rst_d = bus_wdata[FCR_TXRST_BIT];
         end else if (bus_addr == OFS_LCR) begin
            lcr_d = bus_wdata;
         end else if (bus_addr == OFS_MCR) begin
            // bits 3:2 are kept as state only, no pin follows them
            mcr_d = enh_merge(enh, ENH_MCR_MASK, bus_wdata, modem_control_reg_q);
         end else if (bus_addr == OFS_MSR) begin
            dly_d = bus_wdata[7:4];                              // turnaround delay
         end else if (bus_addr == OFS_SPR) begin
            spr_d = bus_wdata;
         end else if (bus_addr == OFS_FEATURE_CONTROL) begin
            feature_control_d = bus_wdata;
         end else if (bus_addr == OFS_EFR) begin
            efr_d = bus_wdata;
         end else if (bus_addr == OFS_TXLVL) begin
            tx_fifo_threshold_d = bus_wdata;
         end else if (bus_addr == OFS_RXLVL) begin
            rx_fifo_threshold_d = bus_wdata;
         end else if (bus_addr == OFS_XFLAG) begin
            stop_char_1_d = bus_wdata;
         end else if (bus_addr == OFS_STOP_CHAR_2) begin
            stop_char_2_d = bus_wdata;
         end else if (bus_addr == OFS_RESUME_CHAR_1) begin
            resume_char_1_d = bus_wdata;
         end else begin
            resume_char_2_d = bus_wdata;
         end
      end else if (bus_rd) begin
         // read decode; data is registered for the next cycle
         if (bus_addr == OFS_HOLD && dlab) begin
            rdata_d = divisor_low_q;
         end else if (bus_addr == OFS_HOLD) begin
            rdata_d  = rx_data;
            rx_pop_d = 1'b1;
         end else if (bus_addr == OFS_IER && dlab) begin
            rdata_d = divisor_high_byte_q;
         end else if (bus_addr == OFS_IER) begin
            rdata_d = interrupt_enable_reg_q;
         end else if (bus_addr == OFS_ISR_FCR) begin
            rdata_d = enh_hide(enh, ENH_ISR_MASK,
                               {{2{fifo_control_reg_q[FCR_EN_BIT]}}, int_code});
            isr_read_d = 1'b1;
         end else if (bus_addr == OFS_LCR) begin
            rdata_d = line_control_reg_q;
         end else if (bus_addr == OFS_MCR) begin
            rdata_d = modem_control_reg_q;
         end else if (bus_addr == OFS_LSR) begin
            rdata_d    = line_stat;
            lsr_read_d = 1'b1;
         end else if (bus_addr == OFS_MSR) begin
            rdata_d    = msr_view;
            msr_read_d = 1'b1;
         end else if (bus_addr == OFS_SPR) begin
            rdata_d = spr_q;
         end else if (bus_addr == OFS_FEATURE_CONTROL) begin
            rdata_d = feature_control_q;
         end else if (bus_addr == OFS_EFR) begin
            rdata_d = enhanced_function_reg_q;
         end else if (bus_addr == OFS_TXLVL) begin
            rdata_d = tx_level;
         end else if (bus_addr == OFS_RXLVL) begin
            rdata_d = rx_level;
         end else if (bus_addr == OFS_XFLAG) begin
            rdata_d = {6'h00, xflag_q};
            xflag_d = 2'b00;                                     // cleared by the read
         end else begin
            rdata_d = RST_ZERO;                                  // write-only characters
         end
      end

      // detection events win over the read that clears them
      if (xoff_seen) begin
         xflag_d[XF_XOFF_BIT] = 1'b1;
      end
      if (xon_seen) begin
         xflag_d[XF_XON_BIT] = 1'b1;
      end
   end

   // ==========================================================
   // register stage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_rdata_q             <= RST_ZERO;
         spr_q                   <= RST_ZERO;
         tx_data_q               <= RST_ZERO;
         tx_load_q               <= 1'b0;
         rx_pop_q                <= 1'b0;
         rx_fifo_rst_q           <= 1'b0;
         tx_fifo_rst_q           <= 1'b0;
         lsr_read_q              <= 1'b0;
         msr_read_q              <= 1'b0;
         isr_read_q              <= 1'b0;
         divisor_low_q           <= RST_DIV_LOW;
         divisor_high_byte_q     <= RST_ZERO;
         interrupt_enable_reg_q  <= RST_ZERO;
         fifo_control_reg_q      <= RST_ZERO;
         line_control_reg_q      <= RST_ZERO;
         modem_control_reg_q     <= RST_ZERO;
         feature_control_q       <= RST_ZERO;
         enhanced_function_reg_q <= RST_ZERO;
         tx_thresh_q             <= RST_ZERO;
         rx_thresh_q             <= RST_ZERO;
         stop_char_1_q           <= RST_ZERO;
         stop_char_2_q           <= RST_ZERO;
         resume_char_1_q         <= RST_ZERO;
         resume_char_2_q         <= RST_ZERO;
         turn_delay_q            <= RST_DLY;
         xflag_q                 <= 2'b00;
      end else begin
         bus_rdata_q             <= rdata_d;
         spr_q                   <= spr_d;
         tx_data_q               <= tx_data_d;
         tx_load_q               <= tx_load_d;
         rx_pop_q                <= rx_pop_d;
         rx_fifo_rst_q           <= rx_fifo_rst_d;
         tx_fifo_rst_q           <= tx_fifo_rst_d;
         lsr_read_q              <= lsr_read_d;
         msr_read_q              <= msr_read_d;
         isr_read_q              <= isr_read_d;
         divisor_low_q           <= dll_d;
         divisor_high_byte_q     <= dlm_d;
         interrupt_enable_reg_q  <= ier_d;
         fifo_control_reg_q      <= fcr_d;
         line_control_reg_q      <= lcr_d;
         modem_control_reg_q     <= mcr_d;
         feature_control_q       <= feature_control_d;
         enhanced_function_reg_q <= efr_d;
         tx_thresh_q             <= tx_fifo_threshold_d;
         rx_thresh_q             <= rx_fifo_threshold_d;
         stop_char_1_q           <= stop_char_1_d;
         stop_char_2_q           <= stop_char_2_d;
         resume_char_1_q         <= resume_char_1_d;
         resume_char_2_q         <= resume_char_2_d;
         turn_delay_q            <= dly_d;
         xflag_q                 <= xflag_d;
      end
   end

endmodule // ucr_channel_regs

// ### tb/ucr_channel_regs_asserts.sv
`timescale 1ns/10ps
// ==========================================
// port checker for the channel register map
module ucr_channel_regs_asserts
   import ucr_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [3:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [7:0] bus_rdata_q,
   input wire logic [7:0] rx_data,
   input wire logic [7:0] tx_data_q,
   input wire logic       tx_load_q,
   input wire logic       rx_pop_q,
   input wire logic       lsr_read_q,
   input wire logic [7:0] divisor_low_q,
   input wire logic [7:0] interrupt_enable_reg_q,
   input wire logic [7:0] line_control_reg_q,
   input wire logic [7:0] modem_control_reg_q,
   input wire logic [7:0] enhanced_function_reg_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // decoded access kinds
   logic rd_go, div_on, enh_on;
   assign rd_go  = bus_rd && !bus_wr;
   assign div_on = line_control_reg_q[LCR_DIV_BIT];
   assign enh_on = enhanced_function_reg_q[EFR_ENH_BIT];
   sequence s_lsr_once;
      rd_go && bus_addr == OFS_LSR ##1 !(rd_go && bus_addr == OFS_LSR);
   endsequence
   sequence s_pulse_lsr;
      lsr_read_q ##1 !lsr_read_q;
   endsequence
   // ==========================================
   // assertions
   chk_tx_load: assert property (bus_wr && bus_addr == OFS_HOLD && !div_on |=>
      tx_load_q && tx_data_q == $past(bus_wdata)) else $error("tx holding write lost");
   chk_rx_read: assert property (rd_go && bus_addr == OFS_HOLD && !div_on |=>
      rx_pop_q && bus_rdata_q == $past(rx_data)) else $error("rx holding read wrong");
   chk_div_write: assert property (bus_wr && bus_addr == OFS_HOLD && div_on |=>
      divisor_low_q == $past(bus_wdata) && !tx_load_q) else $error("divisor low write wrong");
   chk_ier_gate: assert property (bus_wr && bus_addr == OFS_IER && !div_on && !enh_on |=>
      interrupt_enable_reg_q == {$past(interrupt_enable_reg_q[7:4]), $past(bus_wdata[3:0])})
      else $error("ier gated bits changed");
   chk_mcr_gate: assert property (bus_wr && bus_addr == OFS_MCR |=> modem_control_reg_q ==
      ($past(enh_on) ? $past(bus_wdata) : {$past(modem_control_reg_q[7:5]), $past(bus_wdata[4:0])}))
      else $error("mcr write wrong");
   chk_msr_gate: assert property (rd_go && bus_addr == OFS_MSR && !enh_on |=>
      bus_rdata_q[7:4] == 4'h0) else $error("msr gated bits not zero");
   chk_loop_route: assert property (rd_go && bus_addr == OFS_MSR && enh_on &&
      modem_control_reg_q[MCR_LOOP_BIT] |=> bus_rdata_q[7:6] == $past(modem_control_reg_q[3:2]))
      else $error("loopback outputs not routed");
   chk_lsr_pulse: assert property (s_lsr_once |-> s_pulse_lsr) else $error("lsr read pulse wrong");
   chk_rdata_hold: assert property (!rd_go |=> $stable(bus_rdata_q)) else $error("read data moved");
endmodule // ucr_channel_regs_asserts

bind ucr_channel_regs ucr_channel_regs_asserts chk_u (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_wr,
   .bus_rd, .bus_rdata_q, .rx_data, .tx_data_q, .tx_load_q, .rx_pop_q, .lsr_read_q, .divisor_low_q,
   .interrupt_enable_reg_q, .line_control_reg_q, .modem_control_reg_q, .enhanced_function_reg_q);

// ### tb/ucr_host_model.sv
`timescale 1ns/10ps
// ==========================================
// host processor: one strobed access per call
module ucr_host_model
(
   input  wire logic       ref_clk,
   output logic      [3:0] bus_addr,
   output logic      [7:0] bus_wdata,
   output logic            bus_wr,
   output logic            bus_rd,
   input  wire logic [7:0] bus_rdata_q
);
   // idle bus at time zero
   initial begin
      bus_addr = 4'h0;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
   end
   // strobe for one edge, then scramble the released bus and take the answer
   task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      bus_wr <= wr;
      bus_rd <= !wr;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
      #1;
      q = bus_rdata_q;
   endtask
endmodule // ucr_host_model

// ### tb/ucr_channel_regs_tb.sv
`timescale 1ns/10ps
// ==========================================
// self-checking bench for the channel register map
module ucr_channel_regs_tb
   import ucr_pkg::*;
;
   logic       ref_clk, rst, bus_wr, bus_rd, xon_seen, xoff_seen;
   logic [3:0] bus_addr;
   logic [5:0] int_code;
   logic [7:0] bus_wdata, bus_rdata_q, rx_data, line_stat, modem_stat, tx_level, rx_level;
   logic [7:0] tx_data_q, q, d, m, stop_char_1_q;
   logic [3:0] turn_delay_q;
   logic       rx_fifo_rst_q;
   int         fail_count, total_checks, seed;

   ucr_host_model host_u (.ref_clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q);
   ucr_channel_regs dut_u (.ref_clk, .rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_q,
      .rx_data, .int_code, .line_stat, .modem_stat, .tx_level, .rx_level, .xon_seen, .xoff_seen,
      .tx_data_q, .tx_load_q(), .rx_pop_q(), .rx_fifo_rst_q, .tx_fifo_rst_q(), .lsr_read_q(),
      .msr_read_q(), .isr_read_q(), .divisor_low_q(), .divisor_high_byte_q(), .interrupt_enable_reg_q(),
      .fifo_control_reg_q(), .line_control_reg_q(), .modem_control_reg_q(), .feature_control_q(),
      .enhanced_function_reg_q(), .tx_thresh_q(), .rx_thresh_q(), .stop_char_1_q, .stop_char_2_q(),
      .resume_char_1_q(), .resume_char_2_q(), .turn_delay_q, .xflag_q());

   // ==========================================
   // helpers
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      host_u.access(1'b1, a, v, q);
   endtask
   task automatic rd(input logic [3:0] a);
      host_u.access(1'b0, a, 8'h00, q);
   endtask
   // value read back when enhanced bits are gated off
   function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] mask, input logic en);
      return en ? v : (v & ~mask);
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================================
   // watchdog
   initial begin
      #2000000;
      fail_count++;
      print_verdict();
   end

   // ==========================================
   // main sequence
   initial begin
      seed = 56959;
      {rst, xon_seen, xoff_seen, int_code} = {1'b1, 8'h00};
      {rx_data, line_stat, modem_stat, tx_level, rx_level} = 40'h0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      // holding and scratch traffic with random data
      for (int i = 0; i < 16; i++) begin
         d = $random(seed);
         @(posedge ref_clk);
         rx_data <= $random(seed);
         int_code <= $random(seed);
         {line_stat, modem_stat, tx_level, rx_level} <= {$random(seed)};
         wr(OFS_SPR, d);
         rd(OFS_SPR);
         check("scratch", d, q);
         wr(OFS_HOLD, d);
         check("tx data", d, tx_data_q);
         rd(OFS_HOLD);
         check("rx holding", rx_data, q);
      end
      // divisor view of offsets 0 and 1
      wr(OFS_LCR, 8'h83);
      wr(OFS_HOLD, 8'h5a);
      wr(OFS_IER, 8'ha5);
      rd(OFS_HOLD);
      check("divisor low", 8'h5a, q);
      rd(OFS_IER);
      check("divisor high", 8'ha5, q);
      check("tx untouched", d, tx_data_q);
      wr(OFS_LCR, 8'h03);
      rd(OFS_IER);
      check("ier", 8'h00, q);
      // enhanced gating off, then on
      for (int e = 0; e < 2; e++) begin
         m = 8'hf0 | (8'h0c & $random(seed));
         wr(OFS_EFR, e[0] ? 8'h10 : 8'h00);
         wr(OFS_IER, 8'hff);
         rd(OFS_IER);
         check("ier gated", gate(8'hff, ENH_IER_MASK, e[0]), q);
         wr(OFS_MCR, m);
         rd(OFS_MCR);
         check("mcr gated", gate(m, ENH_MCR_MASK, e[0]), q);
         rd(OFS_MSR);
         check("msr loop", gate({m[3:2], 6'h00}, ENH_MSR_MASK, e[0]), q & 8'hc0);
         wr(OFS_ISR_FCR, 8'h01);
         rd(OFS_ISR_FCR);
         check("isr gated", gate({2'b11, int_code}, ENH_ISR_MASK, e[0]), q);
      end
      // status reads, fifo reset pulse, turnaround delay, stop character
      rd(OFS_LSR);
      check("line status", line_stat, q);
      rd(OFS_TXLVL);
      check("tx level", tx_level, q);
      rd(OFS_RXLVL);
      check("rx level", rx_level, q);
      wr(OFS_ISR_FCR, 8'h03);
      check("rx fifo reset", 8'h01, {7'h00, rx_fifo_rst_q});
      wr(OFS_MSR, 8'hc0);
      check("turnaround", 8'h0c, {4'h0, turn_delay_q});
      wr(OFS_XFLAG, 8'h13);
      check("stop char 1", 8'h13, stop_char_1_q);
      rd(OFS_XFLAG);
      check("flags idle", 8'h00, q);
      // resume flag held during the clearing read: the event wins
      @(posedge ref_clk);
      xon_seen <= 1'b1;
      rd(OFS_XFLAG);
      check("resume flag", 8'h02, q);
      @(posedge ref_clk);
      xon_seen <= 1'b0;
      rd(OFS_XFLAG);
      check("set wins", 8'h02, q);
      rd(OFS_XFLAG);
      check("resume cleared", 8'h00, q);
      // detection flag clears on read, write-only place reads zero
      @(posedge ref_clk);
      xoff_seen <= 1'b1;
      @(posedge ref_clk);
      xoff_seen <= 1'b0;
      rd(OFS_XFLAG);
      check("stop flag", 8'h01, q);
      rd(OFS_XFLAG);
      check("flag cleared", 8'h00, q);
      rd(OFS_STOP_CHAR_2);
      check("write only", 8'h00, q);
      print_verdict();
   end
endmodule // ucr_channel_regs_tb
